/* vssc_defs.svh */
// Constant definitions for the VMEbus system signal control block.
`ifndef VSSC_DEFS_SVH
`define VSSC_DEFS_SVH

// ---------------------------------------------------------------
// Line levels
// ---------------------------------------------------------------
`define VSSC_ASSERTED_N     1'h0
`define VSSC_NEGATED_N      1'h1
`define VSSC_DIR_DRIVE      1'h1
`define VSSC_DIR_RECEIVE    1'h0

// ---------------------------------------------------------------
// Widths and reset values
// ---------------------------------------------------------------
`define VSSC_BR_W           4
`define VSSC_LINT_W         8
`define VSSC_BR_NONE        4'h0
`define VSSC_BR_ALL_N       4'hF
`define VSSC_IRQ_NONE       7'h00
`define VSSC_LINT_ALL_N     8'hFF
`define VSSC_ROUTE_W        3

// ---------------------------------------------------------------
// System clock generation (40 MHz / (2 * 2) = 10 MHz)
// ---------------------------------------------------------------
`define VSSC_SYSCLK_HALF    2'h1
// The terminated clock line idles high when nobody drives it.
`define VSSC_SYSCLK_IDLE    1'h1
`define VSSC_DIV_ZERO       2'h0
`define VSSC_SEEN_MAX       4'hF
`define VSSC_SEEN_ZERO      4'h0
`define VSSC_SEEN_ONE       4'h1

`endif

/* vssc_pkg.sv */
// Types for the VMEbus system signal control block.
`default_nettype none
package vssc_pkg;
	`include "vssc_defs.svh"

	// Arbiter states of the system controller.
	typedef enum logic [0:0] {ARB_IDLE, ARB_GRANT} vssc_arb_e;

	// Requester states of the local master.
	typedef enum logic [1:0] {REQ_IDLE, REQ_WAIT, REQ_OWN} vssc_req_e;

	typedef logic [`VSSC_BR_W-1:0] vssc_br_t;
	typedef logic [1:0]             vssc_lvl_t;
endpackage
`default_nettype wire

/* vssc_top.sv */
// VMEbus system signal control: transceiver, arbiter, requester, failure, reset and interrupts.
`timescale 1ns/100ps
`default_nettype none
`include "vssc_defs.svh"
module vssc_top
	import vssc_pkg::*;
(
	input  wire logic             ref_clk,
	input  wire logic             rst_n,
	input  wire logic             syscon_en,
	input  wire logic             bus_isolate,
	input  wire logic             slave_read_float,
	input  wire logic             slave_dtack_req,
	input  wire logic             coupled_target_abort,
	input  wire logic             master_req,
	input  wire vssc_pkg::vssc_lvl_t req_level,
	input  wire logic             ror_mode,
	input  wire logic             master_done,
	input  wire logic             bus_grant_in_n,
	input  wire logic             auto_id_active,
	input  wire logic             sysreset_req,
	input  wire logic             rx_power_fail_warn_n,
	input  wire logic             rx_bus_busy,
	input  wire logic             rx_bus_error,
	input  wire logic [3:0]       rx_bus_request_n,
	input  wire logic [7:1]       rx_vme_irq_n,
	input  wire logic [7:1]       rx_irq_mask,
	input  wire logic [20:0]      rx_irq_route,
	input  wire logic             rx_system_failure_n,
	input  wire logic             rx_system_reset_n,
	input  wire logic             vme_system_clock_in,
	input  wire logic [7:1]       tx_irq_req,
	input  wire logic [7:1]       tx_irq_mask,
	output logic                  xcvr_output_enable_n,
	output logic                  slave_ack_dir,
	output logic                  syscon_lines_dir,
	output logic                  vme_system_clock,
	output logic                  vme_system_clock_oe,
	output logic                  bus_clear_n,
	output logic [3:0]            bus_grant_out_n,
	output logic                  tx_bus_busy,
	output logic                  tx_bus_error,
	output logic [3:0]            tx_bus_request,
	output logic [7:1]            tx_vme_irq,
	output logic                  tx_system_failure,
	output logic                  tx_system_reset,
	output logic                  local_reset_out_n,
	output logic [7:0]            pci_int_n,
	output logic                  transfer_failed,
	output logic                  bus_owned_by_other,
	output logic                  release_requested,
	output logic                  sysclk_seen
);
	import vssc_pkg::*;

	// ---------------------------------------------------------------
	// Reset and state declarations
	// ---------------------------------------------------------------
	logic       blk_rst;
	logic       rx_any_req;
	vssc_arb_e  arb_state, next_arb_state;
	vssc_lvl_t  arb_lvl, next_arb_lvl;
	vssc_req_e  req_state, next_req_state;
	logic [1:0] div_cnt, next_div_cnt;
	logic       sysclk_q, next_sysclk_q;
	logic       sysclk_prev, next_sysclk_prev;
	logic [3:0] seen_cnt, next_seen_cnt;
	logic [7:0] next_pci_int_n;
	logic [3:0] next_grant_n;
	logic       next_bclr_n;
	logic [3:0] next_tx_br;
	logic       next_voe_n;

	// The block resets on its own reset or on the received system reset.
	assign blk_rst    = !rst_n || (rx_system_reset_n == `VSSC_ASSERTED_N);
	assign rx_any_req = |(~rx_bus_request_n);

	// ---------------------------------------------------------------
	// System controller arbiter, priority with level 3 highest
	// ---------------------------------------------------------------
	always_comb begin
		next_arb_state = arb_state;
		next_arb_lvl   = arb_lvl;
		next_grant_n   = `VSSC_BR_ALL_N;
		next_bclr_n    = `VSSC_NEGATED_N;
		unique case (arb_state)
			ARB_IDLE: begin
				// Grant only once the bus is free and a request is pending.
				if (syscon_en && rx_any_req && rx_bus_busy != `VSSC_ASSERTED_N) begin
					next_arb_state = ARB_GRANT;
					for (int i = 0; i < `VSSC_BR_W; i++) begin
						if (!rx_bus_request_n[i]) begin
							next_arb_lvl = 2'(i);
						end
					end
				end
			end
			ARB_GRANT: begin
				next_grant_n[arb_lvl] = `VSSC_ASSERTED_N;
				// Drop the grant once the winner has taken the bus.
				if (!syscon_en || rx_bus_busy == `VSSC_ASSERTED_N ||
						rx_bus_request_n[arb_lvl]) begin
					next_arb_state = ARB_IDLE;
					next_grant_n   = `VSSC_BR_ALL_N;
				end
			end
		endcase
		// Ask the owner to release when a higher level is waiting.
		for (int i = 0; i < `VSSC_BR_W; i++) begin
			if (syscon_en && rx_bus_busy == `VSSC_ASSERTED_N &&
					!rx_bus_request_n[i] && 2'(i) > arb_lvl) begin
				next_bclr_n = `VSSC_ASSERTED_N;
			end
		end
	end

	// ---------------------------------------------------------------
	// Local requester with release on request
	// ---------------------------------------------------------------
	always_comb begin
		next_req_state = req_state;
		next_tx_br     = `VSSC_BR_NONE;
		unique case (req_state)
			REQ_IDLE: begin
				if (master_req) begin
					next_req_state = REQ_WAIT;
				end
			end
			REQ_WAIT: begin
				next_tx_br[req_level] = 1'h1;
				// Take the bus on grant once the previous owner has let go.
				if (!bus_grant_in_n && rx_bus_busy != `VSSC_ASSERTED_N) begin
					next_req_state = REQ_OWN;
					next_tx_br     = `VSSC_BR_NONE;
				end else if (!master_req) begin
					next_req_state = REQ_IDLE;
					next_tx_br     = `VSSC_BR_NONE;
				end
			end
			REQ_OWN: begin
				// Give the bus up when done, or when others ask in that mode.
				if (master_done || (ror_mode && rx_any_req)) begin
					next_req_state = REQ_IDLE;
				end
			end
			default: begin
				next_req_state = REQ_IDLE;
			end
		endcase
	end

	// ---------------------------------------------------------------
	// System clock generation and auto ID clock watch
	// ---------------------------------------------------------------
	always_comb begin
		next_div_cnt     = div_cnt + 2'h1;
		next_sysclk_q    = sysclk_q;
		next_sysclk_prev = vme_system_clock_in;
		next_seen_cnt    = seen_cnt;
		if (!syscon_en) begin
			next_div_cnt  = `VSSC_DIV_ZERO;
			next_sysclk_q = 1'h0;
		end else if (div_cnt == `VSSC_SYSCLK_HALF) begin
			next_div_cnt  = `VSSC_DIV_ZERO;
			next_sysclk_q = !sysclk_q;
		end
		// Count rising edges of the bus clock while auto ID runs.
		if (!auto_id_active) begin
			next_seen_cnt = `VSSC_SEEN_ZERO;
		end else if (vme_system_clock_in && !sysclk_prev && seen_cnt != `VSSC_SEEN_MAX) begin
			next_seen_cnt = seen_cnt + `VSSC_SEEN_ONE;
		end
	end

	// ---------------------------------------------------------------
	// Local interrupt routing of received levels and failures
	// ---------------------------------------------------------------
	always_comb begin
		next_pci_int_n = `VSSC_LINT_ALL_N;
		for (int l = 1; l <= 7; l++) begin
			if (!rx_vme_irq_n[l] && rx_irq_mask[l]) begin
				next_pci_int_n[rx_irq_route[(l-1)*`VSSC_ROUTE_W +: `VSSC_ROUTE_W]] =
					`VSSC_ASSERTED_N;
			end
		end
		if (rx_power_fail_warn_n == `VSSC_ASSERTED_N) begin
			next_pci_int_n[0] = `VSSC_ASSERTED_N;
		end
		if (rx_system_failure_n == `VSSC_ASSERTED_N) begin
			next_pci_int_n[0] = `VSSC_ASSERTED_N;
		end
	end

	// Buffers float in reset, isolation or a floating slave read.
	assign next_voe_n = bus_isolate || slave_read_float;

	// ---------------------------------------------------------------
	// Registers for all state and outputs
	// ---------------------------------------------------------------
	always_ff @(posedge ref_clk) begin
		if (blk_rst) begin
			arb_state            <= ARB_IDLE;
			arb_lvl              <= 2'h0;
			req_state            <= REQ_IDLE;
			div_cnt              <= `VSSC_DIV_ZERO;
			sysclk_q             <= 1'h0;
			sysclk_prev          <= `VSSC_SYSCLK_IDLE;
			seen_cnt             <= `VSSC_SEEN_ZERO;
			xcvr_output_enable_n <= `VSSC_NEGATED_N;
			slave_ack_dir        <= `VSSC_DIR_RECEIVE;
			syscon_lines_dir     <= `VSSC_DIR_RECEIVE;
			vme_system_clock     <= 1'h0;
			vme_system_clock_oe  <= 1'h0;
			bus_clear_n          <= `VSSC_NEGATED_N;
			bus_grant_out_n      <= `VSSC_BR_ALL_N;
			tx_bus_busy          <= 1'h0;
			tx_bus_error         <= 1'h0;
			tx_bus_request       <= `VSSC_BR_NONE;
			tx_vme_irq           <= `VSSC_IRQ_NONE;
			tx_system_failure    <= 1'h1;
			tx_system_reset      <= 1'h0;
			local_reset_out_n    <= `VSSC_ASSERTED_N;
			pci_int_n            <= `VSSC_LINT_ALL_N;
			transfer_failed      <= 1'h0;
			bus_owned_by_other   <= 1'h0;
			release_requested    <= 1'h0;
			sysclk_seen          <= 1'h0;
		end else begin
			arb_state            <= next_arb_state;
			arb_lvl              <= next_arb_lvl;
			req_state            <= next_req_state;
			div_cnt              <= next_div_cnt;
			sysclk_q             <= next_sysclk_q;
			sysclk_prev          <= next_sysclk_prev;
			seen_cnt             <= next_seen_cnt;
			xcvr_output_enable_n <= next_voe_n;
			slave_ack_dir        <= slave_dtack_req ? `VSSC_DIR_DRIVE : `VSSC_DIR_RECEIVE;
			syscon_lines_dir     <= syscon_en ? `VSSC_DIR_DRIVE : `VSSC_DIR_RECEIVE;
			vme_system_clock     <= next_sysclk_q;
			vme_system_clock_oe  <= syscon_en;
			bus_clear_n          <= next_bclr_n;
			bus_grant_out_n      <= next_grant_n;
			tx_bus_busy          <= (next_req_state == REQ_OWN);
			tx_bus_error         <= coupled_target_abort;
			tx_bus_request       <= next_tx_br;
			tx_vme_irq           <= tx_irq_req & tx_irq_mask;
			tx_system_failure    <= auto_id_active;
			tx_system_reset      <= sysreset_req;
			local_reset_out_n    <= `VSSC_NEGATED_N;
			pci_int_n            <= next_pci_int_n;
			transfer_failed      <= (rx_bus_error == `VSSC_ASSERTED_N);
			bus_owned_by_other   <= (rx_bus_busy == `VSSC_ASSERTED_N) && (req_state != REQ_OWN);
			release_requested    <= (req_state == REQ_OWN) && ror_mode && rx_any_req;
			sysclk_seen          <= (next_seen_cnt != `VSSC_SEEN_ZERO);
		end
	end

	// ---------------------------------------------------------------
	// Assertions and covers
	// ---------------------------------------------------------------
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rst_n);

	AST_VOE_RESET: assert property (!rx_system_reset_n |=> xcvr_output_enable_n)
		else $error("Output enable not high after system reset.");
	AST_VOE_ISO: assert property (rx_system_reset_n && bus_isolate |=> xcvr_output_enable_n)
		else $error("Output enable not high in isolation.");
	AST_VOE_READ: assert property (rx_system_reset_n && slave_read_float |=> xcvr_output_enable_n)
		else $error("Output enable not negated for slave read.");
	AST_PFAIL: assert property (rx_system_reset_n && !rx_power_fail_warn_n |=> !pci_int_n[0])
		else $error("Power-fail warning did not raise interrupt.");
	AST_SYSFAIL: assert property (rx_system_reset_n && !rx_system_failure_n |=> !pci_int_n[0])
		else $error("System failure did not raise interrupt.");
	AST_LOCAL_RESET_OUT_N: assert property (!rx_system_reset_n |=> !local_reset_out_n && tx_system_failure)
		else $error("Local reset not asserted on system reset.");
	AST_GRANT_ONEHOT: assert property ($onehot0(~bus_grant_out_n))
		else $error("More than one grant asserted.");
	AST_GRANT_SYSCON: assert property (!syscon_en |=> ##1 bus_grant_out_n == `VSSC_BR_ALL_N)
		else $error("Grant driven while not system controller.");
	AST_BERR: assert property (rx_system_reset_n && !rx_bus_error |=> transfer_failed)
		else $error("Bus error not reported as failure.");
	AST_BUSY_OWN: assert property (tx_bus_busy |-> $past(req_state) != REQ_IDLE || $past(tx_bus_busy))
		else $error("Bus busy without a request.");
	AST_BR_ONE: assert property ($onehot0(tx_bus_request))
		else $error("More than one transmit request.");
	AST_IRQ_MASK: assert property (rx_system_reset_n |=> (tx_vme_irq & ~$past(tx_irq_mask)) == 7'h00)
		else $error("Masked transmit interrupt driven.");
	AST_SYSCLK_OFF: assert property (!syscon_en |=> !vme_system_clock_oe)
		else $error("System clock driven while not system controller.");
	AST_BCLR: assert property (!bus_clear_n |-> $past(syscon_en))
		else $error("Bus clear without system controller role.");
	AST_TXBERR: assert property (rx_system_reset_n && coupled_target_abort |=> tx_bus_error)
		else $error("Target-Abort not signalled as bus error.");

	COV_GRANT: cover property (syscon_en ##1 !bus_grant_out_n[3]);
	COV_OWN: cover property (tx_bus_request != 4'h0 ##[1:20] tx_bus_busy);
	COV_ROR: cover property (release_requested ##1 !tx_bus_busy);
	COV_BCLR: cover property (!bus_clear_n);
endmodule
`default_nettype wire

/* vssc_far_model.sv */
// Behavioural model of the other bus masters, the arbiter and the slaves on the bus.
`timescale 1ns/100ps
`default_nettype none
module vssc_far_model (
	input  wire logic       ref_clk,
	input  wire logic [3:0] tx_bus_request,
	input  wire logic       tx_bus_busy,
	input  wire logic       vme_system_clock,
	input  wire logic       vme_system_clock_oe,
	input  wire logic [3:0] other_req,
	input  wire logic       other_busy,
	input  wire logic       slave_fail,
	input  wire logic [3:0] grant_delay,
	output logic [3:0]      rx_bus_request_n,
	output logic            rx_bus_busy,
	output logic            rx_bus_error,
	output logic            bus_grant_in_n,
	output logic            vme_system_clock_in
);
	logic [3:0] wait_cnt = 4'h0;
	logic       grant_q  = 1'h1;

	// -----------------------------------------------------------
	// Open-collector lines
	// -----------------------------------------------------------
	// Busy is pulled low by either side; request and error lines only by the other masters and the slaves.
	assign rx_bus_request_n = ~other_req;
	assign rx_bus_busy = ~(other_busy | tx_bus_busy);
	assign rx_bus_error = ~slave_fail;
	assign bus_grant_in_n = grant_q;
	// The terminated clock line idles high when the board does not drive it.
	assign vme_system_clock_in = vme_system_clock_oe ? vme_system_clock : 1'h1;

	// -----------------------------------------------------------
	// Remote arbiter
	// -----------------------------------------------------------
	// Grants after a chosen delay, so both prompt and slow answers occur.
	always @(posedge ref_clk) begin
		if (tx_bus_request == 4'h0 || tx_bus_busy) begin
			wait_cnt <= 4'h0;
			grant_q <= 1'h1;
		end else if (wait_cnt >= grant_delay) begin
			grant_q <= 1'h0;
		end else begin
			wait_cnt <= wait_cnt + 4'h1;
		end
	end
endmodule
`default_nettype wire

/* tb_top.sv */
// Self-checking bench for the system signal control block.
`timescale 1ns/100ps
`default_nettype none
module tb_top;
	import vssc_pkg::*;
	typedef struct {int due; int sel; logic [7:0] val;} vssc_note_s;
	logic ref_clk, rst_n, syscon_en, bus_isolate, slave_read_float, slave_dtack_req;
	logic coupled_target_abort, master_req, ror_mode, master_done, auto_id_active;
	logic sysreset_req, rx_power_fail_warn_n, rx_system_failure_n, rx_system_reset_n;
	logic bus_grant_in_n, rx_bus_busy, rx_bus_error, vme_system_clock_in, other_busy;
	logic slave_fail, xcvr_output_enable_n, slave_ack_dir, syscon_lines_dir;
	logic vme_system_clock, vme_system_clock_oe, bus_clear_n, tx_bus_busy, tx_bus_error;
	logic tx_system_failure, tx_system_reset, local_reset_out_n, transfer_failed;
	logic bus_owned_by_other, release_requested, sysclk_seen, prev;
	logic [3:0] rx_bus_request_n, bus_grant_out_n, tx_bus_request, other_req, grant_delay;
	logic [7:1] rx_vme_irq_n, rx_irq_mask, tx_irq_req, tx_irq_mask, tx_vme_irq;
	logic [7:0] pci_int_n;
	logic [20:0] rx_irq_route;
	logic [31:0] r;
	vssc_lvl_t req_level;
	vssc_note_s q[$];
	int cyc, n, num_errors, total_checks;

	vssc_top dut (.*);
	vssc_far_model far (.*);

	// -----------------------------------------------------------
	// Helpers
	// -----------------------------------------------------------
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	function automatic logic [7:0] obs(input int sel);
		case (sel)
			0: return {7'h00, xcvr_output_enable_n};
			1: return {7'h00, slave_ack_dir};
			2: return {7'h00, syscon_lines_dir};
			3: return {7'h00, tx_bus_error};
			4: return {7'h00, tx_system_failure};
			5: return {7'h00, tx_system_reset};
			6: return {7'h00, local_reset_out_n};
			7: return {7'h00, transfer_failed};
			8: return {7'h00, bus_owned_by_other};
			9: return {7'h00, tx_bus_busy};
			10: return {4'h0, bus_grant_out_n};
			11: return {4'h0, tx_bus_request};
			12: return {1'h0, tx_vme_irq};
			13: return pci_int_n;
			14: return {7'h00, sysclk_seen};
			15: return {7'h00, vme_system_clock_oe};
			default: return {7'h00, release_requested};
		endcase
	endfunction
	// Drivers change inputs a fixed 1 ns after each rising edge.
	task automatic tick();
		@(posedge ref_clk);
		#1;
	endtask
	// Records the value a port must show at the falling edge after lat more rising edges.
	task automatic note(input int sel, input logic [7:0] val, input int lat);
		q.push_back('{cyc + lat + 1, sel, val});
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] want);
		total_checks++;
		if (got !== want) begin
			num_errors++;
			$display("BAD %0t count %0d expected %0d", $time, got, want);
		end
	endtask
	task automatic conclude();
		if (num_errors == 0 && total_checks > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask

	// -----------------------------------------------------------
	// Clock, monitor and watchdog
	// -----------------------------------------------------------
	// Clock at 40 MHz.
	initial begin
		ref_clk = 1'h0;
		forever #12.5 ref_clk = ~ref_clk;
	end
	// Compares settled outputs mid-cycle against the oldest due notes.
	always @(negedge ref_clk) begin
		cyc = cyc + 1;
		while (q.size() > 0 && q[0].due <= cyc) begin
			total_checks++;
			if (obs(q[0].sel) !== q[0].val) begin
				num_errors++;
				$display("BAD %0t port %0d got %h want %h", $time, q[0].sel, obs(q[0].sel), q[0].val);
			end
			void'(q.pop_front());
		end
	end
	// Cuts a hang short well beyond the expected run of about 170 cycles.
	initial begin
		#150000;
		num_errors++;
		conclude();
	end

	// -----------------------------------------------------------
	// Main sequence
	// -----------------------------------------------------------
	initial begin
		{rst_n, syscon_en, bus_isolate, slave_read_float, slave_dtack_req} = 5'h00;
		{coupled_target_abort, master_req, ror_mode, master_done, auto_id_active} = 5'h00;
		{sysreset_req, other_busy, slave_fail, num_errors, total_checks} = 0;
		{rx_power_fail_warn_n, rx_system_failure_n, rx_system_reset_n} = 3'h7;
		{other_req, grant_delay, req_level, rx_irq_route} = 0;
		{rx_vme_irq_n, rx_irq_mask, tx_irq_req, tx_irq_mask} = {7'h7F, 21'h0};
		r = 32'h5039;
		repeat (11) tick();
		note(0, 8'h01, 1);
		note(4, 8'h01, 1);
		note(6, 8'h00, 1);
		note(10, 8'h0F, 1);
		note(13, 8'hFF, 1);
		tick();
		rst_n = 1'h1;
		// Random transceiver, error, failure and transmit interrupt traffic.
		for (int i = 0; i < 40; i++) begin
			tick();
			r = lfsr(r);
			{syscon_en, auto_id_active, sysreset_req, coupled_target_abort} = r[3:0];
			{slave_dtack_req, slave_read_float, bus_isolate, slave_fail, other_busy} = r[8:4];
			{tx_irq_req, tx_irq_mask} = r[22:9];
			note(0, {7'h00, r[7] | r[6]}, 1);
			note(1, {7'h00, r[8]}, 1);
			note(2, {7'h00, r[3]}, 1);
			note(3, {7'h00, r[0]}, 1);
			note(4, {7'h00, r[2]}, 1);
			note(5, {7'h00, r[1]}, 1);
			note(7, {7'h00, r[5]}, 1);
			note(8, {7'h00, r[4]}, 1);
			note(12, {1'h0, r[22:16] & r[15:9]}, 1);
		end
		tick();
		{syscon_en, slave_fail, other_busy} = 3'h0;
		// Each received level routed to its own output, then masked.
		for (int l = 1; l < 8; l++) begin
			tick();
			rx_irq_mask = 7'h7F;
			rx_irq_route = 21'h0;
			rx_irq_route[(l - 1) * 3 +: 3] = l[2:0];
			rx_vme_irq_n = ~(7'h01 << (l - 1));
			note(13, ~(8'h01 << l), 1);
			tick();
			rx_irq_mask = ~(7'h01 << (l - 1));
			note(13, 8'hFF, 1);
		end
		tick();
		rx_vme_irq_n = 7'h7F;
		rx_power_fail_warn_n = 1'h0;
		note(13, 8'hFE, 1);
		tick();
		rx_power_fail_warn_n = 1'h1;
		rx_system_failure_n = 1'h0;
		note(13, 8'hFE, 1);
		tick();
		rx_system_failure_n = 1'h1;
		note(13, 8'hFF, 1);
		// Requester at every level, prompt and slow grants, both releases.
		for (int lv = 0; lv < 4; lv++) begin
			tick();
			grant_delay = lv[0] ? 4'h6 : 4'h0;
			req_level = lv[1:0];
			master_req = 1'h1;
			note(11, 8'h01 << lv, 2);
			n = 0;
			while (tx_bus_busy !== 1'h1 && n < 40) begin
				tick();
				n++;
			end
			note(9, 8'h01, 0);
			note(11, 8'h00, 0);
			tick();
			master_req = 1'h0;
			ror_mode = lv[0];
			other_req = {3'h0, lv[0]};
			master_done = ~lv[0];
			note(9, 8'h00, 1);
			note(16, {7'h00, lv[0]}, 1);
			tick();
			{ror_mode, other_req, master_done} = 6'h00;
		end
		// Arbiter grant, hand-over to a new owner, then a higher request.
		tick();
		syscon_en = 1'h1;
		other_req = 4'h1;
		note(10, 8'h0E, 2);
		repeat (3) tick();
		other_busy = 1'h1;
		other_req = 4'h0;
		note(10, 8'h0F, 1);
		repeat (3) tick();
		other_req = 4'h8;
		n = 0;
		while (bus_clear_n !== 1'h0 && n < 6) begin
			tick();
			n++;
		end
		chk(n, 1);
		{other_req, other_busy} = 5'h00;
		// System clock toggles every two cycles only as system controller.
		for (int s = 1; s >= 0; s--) begin
			tick();
			syscon_en = s[0];
			auto_id_active = 1'h0;
			repeat (4) tick();
			// Auto ID watches the bus clock only once the line has settled.
			auto_id_active = 1'h1;
			n = 0;
			prev = vme_system_clock;
			repeat (16) begin
				tick();
				n += (vme_system_clock !== prev);
				prev = vme_system_clock;
			end
			chk(n, s * 8);
			note(14, {7'h00, s[0]}, 0);
			note(15, {7'h00, s[0]}, 0);
		end
		// Received system reset in mid-run.
		tick();
		rx_system_reset_n = 1'h0;
		note(6, 8'h00, 1);
		note(4, 8'h01, 1);
		note(0, 8'h01, 1);
		repeat (2) tick();
		rx_system_reset_n = 1'h1;
		note(6, 8'h01, 1);
		repeat (3) tick();
		conclude();
	end
endmodule
`default_nettype wire
